// ### rtl/port_statistics_counters.sv
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// RL1: Keep thirty statistics counters per switch port.
// RL2: Counter word bit 31 flags overflow.
// RL3: Counter word bit 30 flags valid value.
// RL4: Bits 29:0 hold count, cleared by read.
// RL5: Port blocks at 0x00, 0x20, 0x40.
// RL6: Reads via control register, two 16-bit halves.
// RL7: Offsets 0x0/0x1 count received octets by priority.
// RL8: Offsets 0x2-0x4 undersize, fragment, oversize good.
// RL9: Offset 0x5 counts long errored frames.
// RL10: Offsets 0x6-0x8 symbol, checksum, alignment errors.
// RL11: Offsets 0x9/0xA count control and pause frames.
// RL12: Offsets 0xB-0xD good broadcast, multicast, unicast.
// RL13: Offsets 0xE-0x13 count frames by length bin.
// RL14: Offsets 0x14/0x15 count transmitted octets by priority.
// RL15: Offset 0x16 counts late transmit collisions.
// RL16: Offsets 0x17-0x1A transmit pause, broadcast, multicast, unicast.
// RL17: Offsets 0x1B-0x1D deferred, collisions, excessive collisions.
// RL18: Drop counters are 16 bits, no flags.
// RL19: Drop counters at 0x100-0x102 transmit, 0x103-0x105 receive.
// RL20: Host writes command, reads high half first, retries.
// RL21: Drop counters keep their value when read.
// RL22: Event during clear-on-read is still counted.
// RL23: Undefined per-port offsets read zero, no effects.
module port_statistics_counters #(
    parameter int PORTS   = port_stats_pkg::PORTS,
    parameter int NUM_CNT = port_stats_pkg::NUM_CNT
) (
    input  wire logic                                     clk_sys,
    input  wire logic                                     reset,
    input  wire logic                                     psel,
    input  wire logic                                     penable,
    input  wire logic                                     pwrite,
    input  wire logic [7:0]                               paddr,
    input  wire logic [31:0]                              pwdata,
    output logic                                          pready,
    output logic      [31:0]                              prdata,
    output logic                                          pslverr,
    input  wire port_stats_pkg::rx_event_type [PORTS-1:0] rxEvent,
    input  wire port_stats_pkg::tx_event_type [PORTS-1:0] txEvent,
    input  wire logic [PORTS-1:0]                         txDrop,
    input  wire logic [PORTS-1:0]                         rxDrop
);
    localparam int LEN_W    = port_stats_pkg::LEN_W;
    localparam int COUNT_W  = port_stats_pkg::COUNT_W;
    localparam int DROP_W   = port_stats_pkg::DROP_W;
    localparam int IDX_W    = port_stats_pkg::IDX_W;
    localparam int OFFSET_W = port_stats_pkg::OFFSET_W;
    localparam int CTRL_W   = port_stats_pkg::CTRL_W;

    logic [COUNT_W-1:0]  countFlat [PORTS*NUM_CNT];
    logic                ovfFlat   [PORTS*NUM_CNT];
    logic [LEN_W-1:0]    incFlat   [PORTS*NUM_CNT];
    logic [DROP_W-1:0]   dropFlat  [2*PORTS];
    logic [2*PORTS-1:0]  dropInc;

    logic [CTRL_W-1:0]   ctrl_q;
    logic                pending_q;
    logic [OFFSET_W-1:0] offset_q;
    logic [31:0]         snapshot_q;
    logic [LEN_W-1:0]    maxLen_q;
    logic [31:0]         prdata_q;

    logic                setupPhase;
    logic                accessPhase;
    logic                mapped;
    logic                cmdAccept;
    logic                portHit;
    logic                dropHit;
    logic [IDX_W-1:0]    selIdx;
    logic [2:0]          dropIdx;

    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign mapped      = (paddr == port_stats_pkg::ADDR_INDIRECT_CONTROL) ||
                         (paddr == port_stats_pkg::ADDR_DATA_LOW_HALF) ||
                         (paddr == port_stats_pkg::ADDR_DATA_HIGH_HALF) ||
                         (paddr == port_stats_pkg::ADDR_MAX_FRAME);
    assign pready      = accessPhase;
    assign pslverr     = accessPhase && !mapped;
    assign prdata      = prdata_q;
    assign cmdAccept   = accessPhase && pwrite && (paddr == port_stats_pkg::ADDR_INDIRECT_CONTROL) &&
                         (pwdata[port_stats_pkg::CMD_POS +: 3] == port_stats_pkg::CMD_READ_MIB); // [RL6]

    // Indirect address decode.
    always_comb begin
        portHit = 1'b0;
        dropHit = 1'b0;
        selIdx  = IDX_W'(int'(offset_q[6:5]) * NUM_CNT + int'(offset_q[4:0]));
        dropIdx = 3'(offset_q - port_stats_pkg::DROP_TX_BASE);
        if (offset_q < port_stats_pkg::PORT_AREA_END) begin
            portHit = (int'(offset_q[6:5]) < PORTS) && (int'(offset_q[4:0]) < NUM_CNT); // [RL5] [RL23]
        end else if (offset_q >= port_stats_pkg::DROP_TX_BASE &&
                     offset_q < port_stats_pkg::DROP_TX_BASE + OFFSET_W'(2 * PORTS)) begin
            dropHit = 1'b1; // [RL19]
        end
    end

    // Per-port event decode and counters.
    genvar p;
    genvar i;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            port_stats_pkg::rx_event_type rx;
            port_stats_pkg::tx_event_type tx;
            logic             sizeOk;
            logic             rxErr;
            logic             rxGood;
            logic             txGood;
            logic [LEN_W-1:0] inc [NUM_CNT];

            assign rx     = rxEvent[p];
            assign tx     = txEvent[p];
            assign sizeOk = rx.length >= port_stats_pkg::LEN_MIN && rx.length <= maxLen_q;
            assign rxErr  = rx.crcBad || rx.symbolErr || rx.nonIntegral;
            assign rxGood = rx.done && !rxErr && sizeOk;
            assign txGood = tx.done && !tx.failed;

            always_comb begin
                for (int k = 0; k < NUM_CNT; k++) begin
                    inc[k] = '0;
                end
                inc[port_stats_pkg::RX_LO_OCTETS] = (rx.done && !rx.hiPri) ? rx.length : '0; // [RL7]
                inc[port_stats_pkg::RX_HI_OCTETS] = (rx.done && rx.hiPri) ? rx.length : '0; // [RL7]
                inc[port_stats_pkg::RX_UNDERSIZE] = port_stats_pkg::unit(rx.done && !rxErr &&
                    rx.length < port_stats_pkg::LEN_MIN); // [RL8]
                inc[port_stats_pkg::RX_FRAGMENTS] = port_stats_pkg::unit(rx.done && rxErr &&
                    rx.length < port_stats_pkg::LEN_MIN); // [RL8]
                inc[port_stats_pkg::RX_TOO_LONG_OK] = port_stats_pkg::unit(rx.done && !rxErr &&
                    rx.length > maxLen_q && rx.length <= port_stats_pkg::LEN_ABS_MAX); // [RL8]
                inc[port_stats_pkg::RX_TOO_LONG_ERR] = port_stats_pkg::unit(rx.done && rxErr &&
                    rx.length > maxLen_q); // [RL9]
                inc[port_stats_pkg::RX_SYMBOL_ERR] = port_stats_pkg::unit(rx.done && sizeOk &&
                    rx.symbolErr); // [RL10]
                inc[port_stats_pkg::RX_CHECKSUM_ERR] = port_stats_pkg::unit(rx.done && sizeOk &&
                    rx.crcBad && !rx.nonIntegral); // [RL10]
                inc[port_stats_pkg::RX_ALIGN_ERR] = port_stats_pkg::unit(rx.done && sizeOk &&
                    rx.crcBad && rx.nonIntegral); // [RL10]
                inc[port_stats_pkg::RX_CONTROL] = port_stats_pkg::unit(rx.done && rx.type8808); // [RL11]
                inc[port_stats_pkg::RX_PAUSE] = port_stats_pkg::unit(rx.done && rx.type8808 && rx.pauseDa &&
                    rx.pauseOpcode && !rx.crcBad && rx.length >= port_stats_pkg::LEN_MIN); // [RL11]
                inc[port_stats_pkg::RX_BROADCAST] = port_stats_pkg::unit(rxGood && rx.bcast); // [RL12]
                inc[port_stats_pkg::RX_MULTICAST] = port_stats_pkg::unit(rxGood && rx.mcast &&
                    !rx.bcast && !rx.type8808); // [RL12]
                inc[port_stats_pkg::RX_UNICAST] = port_stats_pkg::unit(rxGood && !rx.mcast &&
                    !rx.bcast); // [RL12]
                inc[port_stats_pkg::RX_BIN_64] = port_stats_pkg::unit(rx.done &&
                    rx.length == port_stats_pkg::LEN_MIN); // [RL13]
                inc[port_stats_pkg::RX_BIN_64 + 1] = port_stats_pkg::unit(rx.done &&
                    rx.length > port_stats_pkg::LEN_MIN && rx.length <= port_stats_pkg::LEN_BIN1_TOP); // [RL13]
                inc[port_stats_pkg::RX_BIN_64 + 2] = port_stats_pkg::unit(rx.done &&
                    rx.length > port_stats_pkg::LEN_BIN1_TOP && rx.length <= port_stats_pkg::LEN_BIN2_TOP);
                inc[port_stats_pkg::RX_BIN_64 + 3] = port_stats_pkg::unit(rx.done &&
                    rx.length > port_stats_pkg::LEN_BIN2_TOP && rx.length <= port_stats_pkg::LEN_BIN3_TOP);
                inc[port_stats_pkg::RX_BIN_64 + 4] = port_stats_pkg::unit(rx.done &&
                    rx.length > port_stats_pkg::LEN_BIN3_TOP && rx.length <= port_stats_pkg::LEN_BIN4_TOP);
                inc[port_stats_pkg::RX_BIN_64 + 5] = port_stats_pkg::unit(rx.done &&
                    rx.length > port_stats_pkg::LEN_BIN4_TOP && rx.length <= port_stats_pkg::LEN_ABS_MAX);
                inc[port_stats_pkg::TX_LO_OCTETS] = (txGood && !tx.hiPri) ? tx.length : '0; // [RL14]
                inc[port_stats_pkg::TX_HI_OCTETS] = (txGood && tx.hiPri) ? tx.length : '0; // [RL14]
                inc[port_stats_pkg::TX_LATE_COLLIDE] = port_stats_pkg::unit(tx.collide &&
                    tx.collideBits > port_stats_pkg::LATE_BITS); // [RL15]
                inc[port_stats_pkg::TX_PAUSE] = port_stats_pkg::unit(tx.done && tx.pause); // [RL16]
                inc[port_stats_pkg::TX_BROADCAST] = port_stats_pkg::unit(txGood && tx.bcast); // [RL16]
                inc[port_stats_pkg::TX_MULTICAST] = port_stats_pkg::unit(txGood && tx.mcast &&
                    !tx.bcast); // [RL16]
                inc[port_stats_pkg::TX_UNICAST] = port_stats_pkg::unit(txGood && !tx.mcast &&
                    !tx.bcast); // [RL16]
                inc[port_stats_pkg::TX_DEFERRED] = port_stats_pkg::unit(tx.done && tx.deferred); // [RL17]
                inc[port_stats_pkg::TX_COLLIDE] = port_stats_pkg::unit(tx.collide && tx.halfDuplex); // [RL17]
                inc[port_stats_pkg::TX_EXCESSIVE] = port_stats_pkg::unit(tx.done && tx.excessive); // [RL17]
            end

            for (i = 0; i < NUM_CNT; i++) begin : g_cnt
                logic clearNow;
                assign clearNow = pending_q && portHit && (selIdx == IDX_W'(p * NUM_CNT + i)); // [RL4]
                assign incFlat[p*NUM_CNT+i] = inc[i];
                stat_counter #(
                    .WIDTH (COUNT_W),
                    .INC_W (LEN_W)
                ) u_counter (
                    .clk_sys   (clk_sys),
                    .reset     (reset),
                    .incAmount (inc[i]),
                    .clearNow  (clearNow),
                    .count     (countFlat[p*NUM_CNT+i]),
                    .overflow  (ovfFlat[p*NUM_CNT+i])
                ); // [RL1]
            end
        end

        // Drop counters wrap silently and are never cleared by a read.
        for (p = 0; p < 2 * PORTS; p++) begin : g_drop
            assign dropInc[p] = (p < PORTS) ? txDrop[p % PORTS] : rxDrop[p % PORTS];
            stat_counter #(
                .WIDTH (DROP_W),
                .INC_W (1)
            ) u_drop (
                .clk_sys   (clk_sys),
                .reset     (reset),
                .incAmount (dropInc[p]),
                .clearNow  (1'b0),
                .count     (dropFlat[p]),
                .overflow  ()
            ); // [RL18] [RL21]
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q <= '0;
        end else if (accessPhase && pwrite && paddr == port_stats_pkg::ADDR_INDIRECT_CONTROL) begin
            ctrl_q <= pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            maxLen_q <= port_stats_pkg::MAX_FRAME_RST;
        end else if (accessPhase && pwrite && paddr == port_stats_pkg::ADDR_MAX_FRAME) begin
            maxLen_q <= pwdata[LEN_W-1:0]; // [RL9]
        end
    end

    // The capture happens one cycle after the command, so a high-half read whose setup phase follows at once still sees the valid flag low.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pending_q <= 1'b0;
            offset_q  <= '0;
        end else if (cmdAccept) begin
            pending_q <= 1'b1;
            offset_q  <= pwdata[OFFSET_W-1:0];
        end else begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            snapshot_q <= '0;
        end else if (cmdAccept) begin
            snapshot_q <= '0; // [RL3]
        end else if (pending_q) begin
            if (portHit) begin
                snapshot_q <= {ovfFlat[selIdx], 1'b1, countFlat[selIdx]}; // [RL2] [RL3] [RL4]
            end else if (dropHit) begin
                snapshot_q <= {16'h0000, dropFlat[dropIdx]}; // [RL18]
            end else begin
                snapshot_q <= '0; // [RL23]
            end
        end
    end

    // Read data is registered in the setup phase so that pready never waits.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata_q <= '0;
        end else if (setupPhase && !pwrite) begin
            if (paddr == port_stats_pkg::ADDR_INDIRECT_CONTROL) begin
                prdata_q <= {19'h00000, ctrl_q};
            end else if (paddr == port_stats_pkg::ADDR_DATA_LOW_HALF) begin
                prdata_q <= {16'h0000, snapshot_q[15:0]}; // [RL6]
            end else if (paddr == port_stats_pkg::ADDR_DATA_HIGH_HALF) begin
                prdata_q <= {16'h0000, snapshot_q[31:16]}; // [RL6]
            end else if (paddr == port_stats_pkg::ADDR_MAX_FRAME) begin
                prdata_q <= {21'h000000, maxLen_q};
            end else begin
                prdata_q <= '0;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_command;
        cmdAccept;
    endsequence

    sequence s_capture;
        pending_q ##1 !pending_q;
    endsequence

    a_capture_after_cmd: assert property (s_command |=> s_capture) // [RL6]
        else $error("command did not lead to a single capture cycle");

    a_valid_on_capture: assert property (s_command ##1 (pending_q && portHit) |=> // [RL3]
        snapshot_q[30] && snapshot_q[31] == $past(ovfFlat[selIdx]))
        else $error("per-port snapshot lacks valid or overflow flag");

    a_invalid_while_busy: assert property (s_command |=> !snapshot_q[30]) // [RL3]
        else $error("valid flag seen before capture");

    a_read_clears: assert property ((pending_q && portHit) |=> // [RL4]
        countFlat[$past(selIdx)] == COUNT_W'($past(incFlat[selIdx])))
        else $error("counter not restarted after read");

    a_drop_kept: assert property ((pending_q && dropHit) |=> // [RL21]
        dropFlat[$past(dropIdx)] == $past(dropFlat[dropIdx]) + DROP_W'($past(dropInc[dropIdx])))
        else $error("drop counter disturbed by read");

    a_undefined_zero: assert property ((pending_q && !portHit && !dropHit) |=> snapshot_q == 32'h00000000) // [RL23]
        else $error("undefined offset returned data");

    a_high_half_read: assert property ((setupPhase && !pwrite && paddr == port_stats_pkg::ADDR_DATA_HIGH_HALF) // [RL6]
        |=> prdata == {16'h0000, $past(snapshot_q[31:16])})
        else $error("high half returns wrong bits");

    a_rx_octets_lo: assert property ((rxEvent[0].done && !rxEvent[0].hiPri) |-> // [RL7]
        incFlat[port_stats_pkg::RX_LO_OCTETS] == rxEvent[0].length)
        else $error("low priority octets not counted");

    a_apb_answer: assert property (setupPhase ##1 accessPhase |-> pready && (pslverr == !mapped))
        else $error("APB access not answered in its first access cycle");

    // Drop words carry no flags.
    a_drop_no_flags: assert property ((pending_q && dropHit) |=> snapshot_q[31:16] == 16'h0000) // [RL18]
        else $error("drop word carries flag bits");

    a_read_clears_ovf: assert property ((pending_q && portHit) |=> !ovfFlat[$past(selIdx)]) // [RL2]
        else $error("overflow flag survived the read");

    a_offset_taken: assert property (s_command |=> offset_q == $past(pwdata[OFFSET_W-1:0])) // [RL6]
        else $error("command offset not taken");

    a_ctrl_stored: assert property (accessPhase && pwrite && // [RL6]
        paddr == port_stats_pkg::ADDR_INDIRECT_CONTROL |=> ctrl_q == $past(pwdata[CTRL_W-1:0]))
        else $error("control write not stored");

    a_unmapped_zero: assert property ((setupPhase && !pwrite && !mapped) |=> prdata == 32'h00000000)
        else $error("unmapped read returned data");

    // Decode checks watch port zero; every port shares one body.
    a_late_collide_edge: assert property (txEvent[0].collide && // [RL15]
        txEvent[0].collideBits <= port_stats_pkg::LATE_BITS |-> incFlat[port_stats_pkg::TX_LATE_COLLIDE] == '0)
        else $error("early collision counted as late");

    a_rx_bin_64: assert property (rxEvent[0].done && rxEvent[0].length == port_stats_pkg::LEN_MIN |-> // [RL13]
        incFlat[port_stats_pkg::RX_BIN_64] == port_stats_pkg::unit(1'b1))
        else $error("short frame not binned");
endmodule

// ### rtl/port_stats_pkg.sv
package port_stats_pkg;

    localparam int PORTS    = 3;
    localparam int NUM_CNT  = 30;
    localparam int COUNT_W  = 30;
    localparam int DROP_W   = 16;
    localparam int LEN_W    = 11;
    localparam int IDX_W    = 7;
    localparam int OFFSET_W = 10;

    // APB register byte addresses.
    localparam logic [7:0] ADDR_INDIRECT_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_DATA_LOW_HALF    = 8'h04;
    localparam logic [7:0] ADDR_DATA_HIGH_HALF   = 8'h08;
    localparam logic [7:0] ADDR_MAX_FRAME        = 8'h0C;

    // Indirect control word: command in bits 12:10, offset in bits 9:0.
    localparam int         CMD_POS      = 10;
    localparam logic [2:0] CMD_READ_MIB = 3'h7;
    localparam int         CTRL_W       = 13;

    // Indirect address map.
    localparam logic [OFFSET_W-1:0] PORT_AREA_END = 10'h060;
    localparam logic [OFFSET_W-1:0] DROP_TX_BASE  = 10'h100;
    localparam logic [OFFSET_W-1:0] DROP_RX_BASE  = 10'h103;

    // Counter offsets inside one 32-entry port block.
    localparam int RX_LO_OCTETS    = 'h00;
    localparam int RX_HI_OCTETS    = 'h01;
    localparam int RX_UNDERSIZE    = 'h02;
    localparam int RX_FRAGMENTS    = 'h03;
    localparam int RX_TOO_LONG_OK  = 'h04;
    localparam int RX_TOO_LONG_ERR = 'h05;
    localparam int RX_SYMBOL_ERR   = 'h06;
    localparam int RX_CHECKSUM_ERR = 'h07;
    localparam int RX_ALIGN_ERR    = 'h08;
    localparam int RX_CONTROL      = 'h09;
    localparam int RX_PAUSE        = 'h0A;
    localparam int RX_BROADCAST    = 'h0B;
    localparam int RX_MULTICAST    = 'h0C;
    localparam int RX_UNICAST      = 'h0D;
    localparam int RX_BIN_64       = 'h0E;
    localparam int TX_LO_OCTETS    = 'h14;
    localparam int TX_HI_OCTETS    = 'h15;
    localparam int TX_LATE_COLLIDE = 'h16;
    localparam int TX_PAUSE        = 'h17;
    localparam int TX_BROADCAST    = 'h18;
    localparam int TX_MULTICAST    = 'h19;
    localparam int TX_UNICAST      = 'h1A;
    localparam int TX_DEFERRED     = 'h1B;
    localparam int TX_COLLIDE      = 'h1C;
    localparam int TX_EXCESSIVE    = 'h1D;

    // Frame length limits in octets; late-collision limit in bits.
    localparam logic [LEN_W-1:0] LEN_MIN       = 11'h040;
    localparam logic [LEN_W-1:0] LEN_BIN1_TOP  = 11'h07F;
    localparam logic [LEN_W-1:0] LEN_BIN2_TOP  = 11'h0FF;
    localparam logic [LEN_W-1:0] LEN_BIN3_TOP  = 11'h1FF;
    localparam logic [LEN_W-1:0] LEN_BIN4_TOP  = 11'h3FF;
    localparam logic [LEN_W-1:0] LEN_ABS_MAX   = 11'h7D0;
    localparam logic [LEN_W-1:0] MAX_FRAME_RST = 11'h5F2;
    localparam logic [11:0]      LATE_BITS     = 12'h200;

    typedef struct packed {
        logic             done;
        logic [LEN_W-1:0] length;
        logic             hiPri;
        logic             crcBad;
        logic             symbolErr;
        logic             nonIntegral;
        logic             bcast;
        logic             mcast;
        logic             type8808;
        logic             pauseDa;
        logic             pauseOpcode;
    } rx_event_type;

    typedef struct packed {
        logic             done;
        logic [LEN_W-1:0] length;
        logic             hiPri;
        logic             failed;
        logic             bcast;
        logic             mcast;
        logic             pause;
        logic             deferred;
        logic             excessive;
        logic             collide;
        logic [11:0]      collideBits;
        logic             halfDuplex;
    } tx_event_type;

    function automatic logic [LEN_W-1:0] unit(input logic b);
        return {{(LEN_W-1){1'b0}}, b};
    endfunction

endpackage

// ### rtl/stat_counter.sv
`timescale 1ns/10ps
module stat_counter #(
    parameter int WIDTH = 30,
    parameter int INC_W = 11
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [INC_W-1:0] incAmount,
    input  wire logic             clearNow,
    output logic      [WIDTH-1:0] count,
    output logic                  overflow
);
    logic [WIDTH-1:0] count_q;
    logic             overflow_q;
    logic [WIDTH:0]   sum;

    assign sum      = {1'b0, count_q} + (WIDTH+1)'(incAmount);
    assign count    = count_q;
    assign overflow = overflow_q;

    // A clear that meets an event restarts from the event's amount.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_q <= '0;
        end else if (clearNow) begin
            count_q <= WIDTH'(incAmount); // [RL22] [RL4]
        end else begin
            count_q <= sum[WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            overflow_q <= 1'b0;
        end else if (clearNow) begin
            overflow_q <= 1'b0;
        end else if (sum[WIDTH]) begin
            overflow_q <= 1'b1; // [RL2]
        end
    end

    a_count_step: assert property (@(posedge clk_sys) disable iff (reset) // [RL22]
        !clearNow |=> count_q == $past(sum[WIDTH-1:0]))
        else $error("counter did not add its increment");

    a_ovf_sticky: assert property (@(posedge clk_sys) disable iff (reset) // [RL2]
        (!clearNow && sum[WIDTH]) |=> overflow_q)
        else $error("overflow flag not set on carry");
endmodule

// ### testbench/port_statistics_counters_tb_top.sv
`timescale 1ns/10ps
module port_statistics_counters_tb_top;
    logic                                   clk_sys, reset, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]                             paddr;
    logic [31:0]                            pwdata, prdata, w;
    port_stats_pkg::rx_event_type [2:0]     rxEvent;
    port_stats_pkg::tx_event_type [2:0]     txEvent;
    logic [2:0]                             txDrop, rxDrop;
    int                                     failures, compares;
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    port_statistics_counters dut_u (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rxEvent(rxEvent), .txEvent(txEvent), .txDrop(txDrop), .rxDrop(rxDrop));
    stats_host_model host_u (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    task automatic final_report();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [9:0] off, input logic [31:0] exp);
        logic [31:0] got;
        host_u.read_counter(off, got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t offset %h read %h expected %h", $time, off, got, exp);
        end
    endtask
    function automatic logic [31:0] ok(input int n);
        return {2'b01, n[29:0]};
    endfunction
    task automatic rx(input int p, input logic [10:0] len, input logic [8:0] f);
        @(posedge clk_sys);
        rxEvent[p] <= {1'b1, len, f};
        @(posedge clk_sys);
        rxEvent[p] <= '0;
    endtask
    task automatic tx(input int p, input logic [32:0] v);
        @(posedge clk_sys);
        txEvent[p] <= v;
        @(posedge clk_sys);
        txEvent[p] <= '0;
    endtask
    initial begin
        {reset, rxEvent, txEvent, txDrop, rxDrop, failures, compares} = {1'b1, 232'h0};
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        check(10'h000, ok(0));
        rx(0, 11'h040, 9'h000);
        check(10'h000, ok(64));
        check(10'h000, ok(0));
        check(10'h00E, ok(1));
        check(10'h00D, ok(1));
        rx(1, 11'h064, 9'h180);
        check(10'h021, ok(100));
        check(10'h027, ok(1));
        check(10'h02F, ok(1));
        rx(0, 11'h640, 9'h000);
        rx(0, 11'h640, 9'h040);
        check(10'h004, ok(1));
        check(10'h005, ok(1));
        check(10'h013, ok(2));
        rx(0, 11'h040, 9'h00F);
        check(10'h009, ok(1));
        check(10'h00A, ok(1));
        check(10'h00C, ok(0));
        tx(2, {1'b1, 11'h0C8, 7'h10, 14'h0});
        check(10'h054, ok(200));
        check(10'h058, ok(1));
        tx(0, {1'b0, 11'h0, 7'h0, 1'b1, 12'h200, 1'b1});
        tx(0, {1'b0, 11'h0, 7'h0, 1'b1, 12'h201, 1'b1});
        check(10'h016, ok(1));
        check(10'h01C, ok(2));
        repeat (2) begin
            @(posedge clk_sys);
            txDrop <= 3'h2;
            rxDrop <= 3'h4;
            @(posedge clk_sys);
            txDrop <= 3'h0;
            rxDrop <= 3'h0;
        end
        check(10'h101, 32'h2);
        check(10'h101, 32'h2);
        check(10'h105, 32'h2);
        check(10'h01E, 32'h0);
        // The pulse lands on the capture edge, one edge after the command is taken.
        host_u.apb(1'b1, port_stats_pkg::ADDR_INDIRECT_CONTROL, 32'h1C0E, w, e);
        rxEvent[0] <= {1'b1, 11'h040, 9'h000};
        @(posedge clk_sys);
        rxEvent[0] <= '0;
        check(10'h00E, ok(1));
        host_u.apb(1'b0, 8'h10, 32'h0, w, e);
        compares++;
        if (e !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t unmapped address gave no error", $time);
        end
        final_report();
    end
endmodule

// ### testbench/stats_host_model.sv
`timescale 1ns/10ps
module stats_host_model (
    input  wire logic        clk_sys,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            port_statistics_counters_tb_top.failures++;
            port_statistics_counters_tb_top.final_report();
        end
    endtask
    // Drop counters carry no valid flag, so only per-port words are polled again.
    task automatic read_counter(input logic [9:0] off, output logic [31:0] word);
        logic [31:0] rd;
        logic        e;
        int          n;
        apb(1'b1, port_stats_pkg::ADDR_INDIRECT_CONTROL, {19'h0, port_stats_pkg::CMD_READ_MIB, off}, rd, e);
        n = 0;
        do begin
            apb(1'b0, port_stats_pkg::ADDR_DATA_HIGH_HALF, 32'h0, rd, e);
            n++;
        end while (rd[14] !== 1'b1 && off < 10'h100 && n < 8);
        word[31:16] = rd[15:0];
        apb(1'b0, port_stats_pkg::ADDR_DATA_LOW_HALF, 32'h0, rd, e);
        word[15:0] = rd[15:0];
    endtask
endmodule
